// ==== rtl/cmpc_top.sv ====
/*
  Comparator digital control: enable, response mode, hysteresis, latched and raw outputs,
  sticky edge flags, interrupt requests and an APB register file.
  Assumes an analog core that produces cmp_raw asynchronously, a crossbar that takes the outputs,
  and an interrupt controller that takes the two level requests.
*/
// Added by the designer: register access over APB and the register offsets.
// Function
// - Offer a clock-latched output and a raw copy of the comparator result.
// - Raw output follows the comparator without any clock, also in stop mode.
// - Comparator result is offered as a selectable reset source.
// - Result usable by polling, interrupts and pin routing simultaneously.
// - When disabled, pin outputs are low and comparator power is off.
// - Response mode field drives the analog core speed and power setting.
// - Control low four bits hold positive and negative hysteresis fields.
// - Rising and falling interrupts are handled independently.
// - Each falling transition sets the falling-edge flag.
// - Each rising transition sets the rising-edge flag.
// - Edge flags are sticky; only a software write of 0 clears them.
// - Rising interrupt request only when rising flag and its enable are set.
// - Falling interrupt request only when falling flag and its enable are set.
// - Output-state bit is read-only and returns the current result.
// - Enable bit written 1 turns comparator on, 0 turns it off.
// - Control: enable bit 7, state bit 6, rise flag 5, fall flag 4, reset 0.
// - Hysteresis codes: 00 off, 01 5 mV, 10 10 mV, 11 20 mV.
// - Mode field 0 fastest to 3 slowest, resets to 2; enables at bits 5, 4.
`timescale 1ns/1ns
`include "cmpc_cfg.svh"
module cmpc_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog core
  input  wire logic        cmp_raw,
  output logic             cmp_power_en,
  output logic      [1:0]  response_mode_sel,
  output logic      [1:0]  pos_hysteresis_sel,
  output logic      [1:0]  neg_hysteresis_sel,
  // Crossbar and reset logic
  output logic             latched_compare_out,
  output logic             raw_compare_out,
  output logic             cmp_reset_src,
  // Interrupt requests
  output logic             rise_irq,
  output logic             fall_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic                compare_enable_reg;
  logic                rise_edge_flag_reg;
  logic                fall_edge_flag_reg;
  cmpc_pkg::cmpc_hys_t pos_hys_reg;
  cmpc_pkg::cmpc_hys_t neg_hys_reg;
  logic                rise_irq_enable_reg;
  logic                fall_irq_enable_reg;
  cmpc_pkg::cmpc_mode_t response_mode_reg;
  logic                latched_reg;

  logic                wr_ctrl;
  logic                wr_mode;
  logic                hit_ctrl;
  logic                hit_mode;
  logic                unmapped;
  logic                compare_state;
  logic [7:0]          ctrl_rd;
  logic [7:0]          mode_rd;

  cmpc_edge_if edge_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser and edge detect

  cmpc_sync_edge #(
    .STAGES (`CMPC_SYNC_STAGES)
  ) u_sync (
    .mclk   (mclk),
    .rst    (rst),
    .raw_in (cmp_raw),
    .edge_o (edge_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  cmpc_apb_regs u_dec (
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .wr_ctrl  (wr_ctrl),
    .wr_mode  (wr_mode),
    .hit_ctrl (hit_ctrl),
    .hit_mode (hit_mode),
    .unmapped (unmapped)
  );

  // Zero wait states; unmapped access errors, reads zero, writes nothing
  assign pready  = 1'b1;
  assign pslverr = psel & penable & unmapped;

  ////////////////////////////////////////////////////////////////////////////
  // Enable

  // Only the low byte lane holds fields
  always_ff @(posedge mclk) begin
    if (rst) begin
      compare_enable_reg <= 1'b0;
    end else if (wr_ctrl && pstrb[0]) begin
      compare_enable_reg <= pwdata[`CMPC_CTRL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hysteresis

  always_ff @(posedge mclk) begin
    if (rst) begin
      pos_hys_reg <= `CMPC_HYS_RST;
      neg_hys_reg <= `CMPC_HYS_RST;
    end else if (wr_ctrl && pstrb[0]) begin
      pos_hys_reg <= pwdata[`CMPC_CTRL_HYP_HI:`CMPC_CTRL_HYP_LO];
      neg_hys_reg <= pwdata[`CMPC_CTRL_HYN_HI:`CMPC_CTRL_HYN_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky edge flags

  // Edge wins over a software clear in the same cycle; writing 1 has no effect
  always_ff @(posedge mclk) begin
    if (rst) begin
      rise_edge_flag_reg <= 1'b0;
    end else if (edge_bus.rise) begin
      rise_edge_flag_reg <= 1'b1;
    end else if (wr_ctrl && pstrb[0] && !pwdata[`CMPC_CTRL_RISE_BIT]) begin
      rise_edge_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fall_edge_flag_reg <= 1'b0;
    end else if (edge_bus.fall) begin
      fall_edge_flag_reg <= 1'b1;
    end else if (wr_ctrl && pstrb[0] && !pwdata[`CMPC_CTRL_FALL_BIT]) begin
      fall_edge_flag_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode register

  always_ff @(posedge mclk) begin
    if (rst) begin
      rise_irq_enable_reg <= 1'b0;
      fall_irq_enable_reg <= 1'b0;
      response_mode_reg   <= cmpc_pkg::cmpc_mode_t'(`CMPC_MODE_RST);
    end else if (wr_mode && pstrb[0]) begin
      rise_irq_enable_reg <= pwdata[`CMPC_MODE_RIE_BIT];
      fall_irq_enable_reg <= pwdata[`CMPC_MODE_FIE_BIT];
      response_mode_reg   <= cmpc_pkg::cmpc_mode_t'(pwdata[`CMPC_MODE_MD_HI:`CMPC_MODE_MD_LO]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator outputs

  // Disabled comparator reads as low so no false state escapes
  assign compare_state = compare_enable_reg & edge_bus.level;

  always_ff @(posedge mclk) begin
    if (rst) begin
      latched_reg <= 1'b0;
    end else begin
      latched_reg <= compare_state;
    end
  end

  // Gated by the enable so the pin drops in the same cycle as the disable
  assign latched_compare_out = latched_reg & compare_enable_reg;
  // Purely combinational so it works with mclk stopped
  assign raw_compare_out     = compare_enable_reg & cmp_raw;
  assign cmp_reset_src       = latched_reg & compare_enable_reg;
  assign cmp_power_en        = compare_enable_reg;
  assign response_mode_sel   = response_mode_reg;
  assign pos_hysteresis_sel  = pos_hys_reg;
  assign neg_hysteresis_sel  = neg_hys_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests

  assign rise_irq = rise_edge_flag_reg & rise_irq_enable_reg;
  assign fall_irq = fall_edge_flag_reg & fall_irq_enable_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`CMPC_CTRL_EN_BIT]   = compare_enable_reg;
    ctrl_rd[`CMPC_CTRL_OUT_BIT]  = compare_state;
    ctrl_rd[`CMPC_CTRL_RISE_BIT] = rise_edge_flag_reg;
    ctrl_rd[`CMPC_CTRL_FALL_BIT] = fall_edge_flag_reg;
    ctrl_rd[`CMPC_CTRL_HYP_HI:`CMPC_CTRL_HYP_LO] = pos_hys_reg;
    ctrl_rd[`CMPC_CTRL_HYN_HI:`CMPC_CTRL_HYN_LO] = neg_hys_reg;
  end

  always_comb begin
    mode_rd = 8'h00;
    mode_rd[`CMPC_MODE_RIE_BIT] = rise_irq_enable_reg;
    mode_rd[`CMPC_MODE_FIE_BIT] = fall_irq_enable_reg;
    mode_rd[`CMPC_MODE_MD_HI:`CMPC_MODE_MD_LO] = response_mode_reg;
  end

  // Registered read data, loaded in the setup phase so it is ready at the access edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= {24'h00_0000, ctrl_rd};
      end else if (hit_mode) begin
        prdata <= {24'h00_0000, mode_rd};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// ==== rtl/cmpc_cfg.svh ====
/*
  Register offsets, field positions, reset values and widths of the comparator control block.
  Assumes inclusion by bare name from any file that needs it.
*/
`ifndef CMPC_CFG_SVH
`define CMPC_CFG_SVH

// Register byte addresses on the APB
`define CMPC_CTRL_ADDR     12'h000
`define CMPC_MODE_ADDR     12'h004
`define CMPC_ADDR_W        12

// Control register fields
`define CMPC_CTRL_EN_BIT   7
`define CMPC_CTRL_OUT_BIT  6
`define CMPC_CTRL_RISE_BIT 5
`define CMPC_CTRL_FALL_BIT 4
`define CMPC_CTRL_HYP_HI   3
`define CMPC_CTRL_HYP_LO   2
`define CMPC_CTRL_HYN_HI   1
`define CMPC_CTRL_HYN_LO   0

// Mode register fields
`define CMPC_MODE_RIE_BIT  5
`define CMPC_MODE_FIE_BIT  4
`define CMPC_MODE_MD_HI    1
`define CMPC_MODE_MD_LO    0

// Reset values
`define CMPC_HYS_RST       2'h0
`define CMPC_MODE_RST      2'h2

// Synchroniser depth
`define CMPC_SYNC_STAGES   2

`endif

// ==== rtl/cmpc_pkg.sv ====
/*
  Types shared by the comparator control block.
  Assumes cmpc_cfg.svh is available for constants.
*/
package cmpc_pkg;

  typedef logic [1:0] cmpc_hys_t;

  typedef enum logic [1:0] {
    CMPC_MODE0,
    CMPC_MODE1,
    CMPC_MODE2,
    CMPC_MODE3
  } cmpc_mode_t;

endpackage

// ==== rtl/cmpc_edge_if.sv ====
/*
  Interface carrying the synchronised comparator level and its edge pulses.
  Assumes one clock domain, the system clock.
*/
`timescale 1ns/1ns
interface cmpc_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ==== rtl/cmpc_sync_edge.sv ====
/*
  Two-flop synchroniser for the raw comparator result with edge detection on the synchronised level.
  Assumes the raw input is asynchronous to mclk.
*/
`timescale 1ns/1ns
`include "cmpc_cfg.svh"
module cmpc_sync_edge #(
  parameter int STAGES = `CMPC_SYNC_STAGES
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Asynchronous input
  input  wire logic raw_in,
  // Synchronised outputs
  cmpc_edge_if.src  edge_o
);

  // Fewer than two stages would let a metastable level reach the edge detect
  if (STAGES < 2) begin : g_stages_bad
    $error("cmpc_sync_edge: STAGES must be at least 2");
  end

  logic [STAGES-1:0] sync_reg;
  logic              prev_reg;

  // Only the last stage is read by anything
  always_ff @(posedge mclk) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= {sync_reg[STAGES-2:0], raw_in};
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= sync_reg[STAGES-1];
    end
  end

  assign edge_o.level = sync_reg[STAGES-1];
  assign edge_o.rise  = sync_reg[STAGES-1] & ~prev_reg;
  assign edge_o.fall  = ~sync_reg[STAGES-1] & prev_reg;

endmodule

// ==== rtl/cmpc_apb_regs.sv ====
/*
  APB slave decode helper: produces write and read strobes for the comparator registers.
  Assumes APB3 signalling on mclk; the slave answers with zero wait states.
*/
`timescale 1ns/1ns
`include "cmpc_cfg.svh"
module cmpc_apb_regs (
  // APB request
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [`CMPC_ADDR_W-1:0]   paddr,
  // Decoded strobes
  output logic                           wr_ctrl,
  output logic                           wr_mode,
  output logic                           hit_ctrl,
  output logic                           hit_mode,
  output logic                           unmapped
);

  function automatic logic addr_is(input logic [`CMPC_ADDR_W-1:0] a, input logic [`CMPC_ADDR_W-1:0] b);
    addr_is = (a == b);
  endfunction

  logic access;

  assign access   = psel & penable;
  assign hit_ctrl = addr_is(paddr, `CMPC_CTRL_ADDR);
  assign hit_mode = addr_is(paddr, `CMPC_MODE_ADDR);
  assign wr_ctrl  = access & pwrite & hit_ctrl;
  assign wr_mode  = access & pwrite & hit_mode;
  assign unmapped = ~hit_ctrl & ~hit_mode;

endmodule

// ==== tb/cmpc_chk.sv ====
/* Assertions on the comparator control top ports.
   Assumes the register map of cmpc_cfg.svh and one clock. */
`timescale 1ns/1ns
module cmpc_chk (
  // Clock and APB
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pslverr,
  // Comparator side
  input wire logic        cmp_raw,
  input wire logic        cmp_power_en,
  input wire logic [1:0]  response_mode_sel,
  input wire logic        latched_compare_out,
  input wire logic        raw_compare_out,
  input wire logic        cmp_reset_src,
  input wire logic        rise_irq,
  input wire logic        fall_irq
);
  logic       wr_ctrl;
  logic       wr_mode;
  logic [7:0] mode_reg;

  assign wr_ctrl = psel && penable && pwrite && pstrb[0] && paddr == 12'h000;
  assign wr_mode = psel && penable && pwrite && pstrb[0] && paddr == 12'h004;

  // Shadow of the mode register, so the gates can be judged
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_reg <= 8'h02;
    end else if (wr_mode) begin
      mode_reg <= pwdata[7:0] & 8'h33;
    end
  end

  ////////////////////////////////////////
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_raw_gated: assert property (raw_compare_out == (cmp_power_en && cmp_raw))
    else $error("raw output not a gated copy");
  a_off_low: assert property (!cmp_power_en |-> !latched_compare_out)
    else $error("latched output high while off");
  a_latch_delay: assert property (cmp_power_en [*5] |-> latched_compare_out == $past(cmp_raw, 3))
    else $error("latched output late or wrong");
  a_unmapped_err: assert property (pslverr == (psel && penable && paddr != 12'h000 && paddr != 12'h004))
    else $error("error response on wrong access");
  a_reset_src: assert property (cmp_reset_src == latched_compare_out)
    else $error("reset source differs");
  a_rise_gate: assert property (rise_irq |-> mode_reg[5])
    else $error("rise request while masked");
  a_fall_gate: assert property (fall_irq |-> mode_reg[4])
    else $error("fall request while masked");
  a_rise_sticky: assert property (rise_irq && !wr_ctrl && !wr_mode |=> rise_irq)
    else $error("rise flag lost");
  a_fall_sticky: assert property (fall_irq && !wr_ctrl && !wr_mode |=> fall_irq)
    else $error("fall flag lost");
  a_rise_flag: assert property ($rose(cmp_raw) && mode_reg[5] |-> ##[1:5] rise_irq)
    else $error("rising edge not flagged");
  a_fall_flag: assert property ($fell(cmp_raw) && mode_reg[4] |-> ##[1:5] fall_irq)
    else $error("falling edge not flagged");
  a_mode_out: assert property (response_mode_sel == mode_reg[1:0])
    else $error("mode output differs");
endmodule

bind cmpc_top cmpc_chk cmpc_chk_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr,
  .cmp_raw, .cmp_power_en, .response_mode_sel, .latched_compare_out, .raw_compare_out,
  .cmp_reset_src, .rise_irq, .fall_irq);

// ==== tb/cmpc_analog_model.sv ====
/* Analog comparator core: follows a target level, slower in slower modes.
   Assumes the bench moves target right after a clock edge. */
`timescale 1ns/1ns
module cmpc_analog_model (
  // Clock and controls
  input  wire logic       mclk,
  input  wire logic       power_en,
  input  wire logic [1:0] mode,
  // Bench level and result
  input  wire logic       target,
  output logic            raw
);
  logic [1:0] wait_reg = 2'h0;

  initial raw = 1'b0;

  // Unpowered core tracks at once, so output gating stays visible
  always @(posedge mclk) begin
    if (raw == target) begin
      wait_reg <= 2'h0;
    end else if (!power_en || wait_reg == mode) begin
      raw <= target;
      wait_reg <= 2'h0;
    end else begin
      wait_reg <= wait_reg + 2'h1;
    end
  end
endmodule

// ==== tb/tb_cmpc_top.sv ====
/* Self-checking bench for the comparator control block.
   Assumes zero-wait APB and the analog model beside it. */
`timescale 1ns/1ns
module tb_cmpc_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        target = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, cmp_raw, cmp_power_en, cmp_reset_src;
  logic        latched_compare_out, raw_compare_out, rise_irq, fall_irq;
  logic [1:0]  response_mode_sel, pos_hysteresis_sel, neg_hysteresis_sel;
  logic [31:0] exp_q[$];
  logic [31:0] rnd = 32'hd993;
  int          fails = 0;
  int          n_compared = 0;

  always #4 mclk = ~mclk;

  cmpc_top cmpc_top_inst (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .cmp_raw, .cmp_power_en, .response_mode_sel, .pos_hysteresis_sel,
    .neg_hysteresis_sel, .latched_compare_out, .raw_compare_out, .cmp_reset_src, .rise_irq, .fall_irq);
  cmpc_analog_model cmpc_analog_model_inst (.mclk(mclk), .power_en(cmp_power_en),
    .mode(response_mode_sel), .target(target), .raw(cmp_raw));

  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0, 4'hf);
  endtask

  // Polls rise request, fall request or latched output, bounded
  task automatic wait_hi(input int sel);
    int i;
    logic v;
    for (i = 0; i < 24; i++) begin
      v = sel == 0 ? rise_irq : sel == 1 ? fall_irq : latched_compare_out;
      if (v === 1'b1) break;
      @(posedge mclk);
    end
    check({31'h0, v}, 32'h1);
    if (v !== 1'b1) begin
      stop_test();
    end
  endtask

  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) begin
      check(prdata, exp_q.pop_front());
    end
  end

  ////////////////////////////////////////
  initial begin
    int i;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h2);
    rd(12'h008, 32'h0);
    apb(1'b1, 12'h004, 32'hffffffff, 4'hf);
    rd(12'h004, 32'h33);
    for (i = 0; i < 16; i++) begin
      rnd = xs(rnd);
      apb(1'b1, 12'h004, {30'h0, rnd[1:0]}, 4'hf);
      apb(1'b1, 12'h000, 32'h80 | i, 4'hf);
      rd(12'h000, 32'h80 | i);
      check({30'h0, pos_hysteresis_sel}, i >> 2);
      check({30'h0, neg_hysteresis_sel}, i & 3);
      check({30'h0, response_mode_sel}, {30'h0, rnd[1:0]});
    end
    apb(1'b1, 12'h000, 32'h80, 4'hf);
    apb(1'b1, 12'h004, 32'h30, 4'hf);
    target <= 1'b1;
    wait_hi(0);
    check({31'h0, fall_irq}, 32'h0);
    check({31'h0, raw_compare_out}, 32'h1);
    rd(12'h000, 32'he0);
    check({31'h0, latched_compare_out}, 32'h1);
    apb(1'b1, 12'h000, 32'ha0, 4'hf);
    target <= 1'b0;
    wait_hi(1);
    rd(12'h000, 32'hb0);
    check({31'h0, rise_irq}, 32'h1);
    apb(1'b1, 12'h000, 32'h80, 4'hf);
    rd(12'h000, 32'h80);
    apb(1'b1, 12'h004, 32'h13, 4'hf);
    target <= 1'b1;
    wait_hi(2);
    check({31'h0, rise_irq}, 32'h0);
    rd(12'h000, 32'he0);
    apb(1'b1, 12'h000, 32'h0, 4'he);
    rd(12'h000, 32'he0);
    apb(1'b1, 12'h004, 32'h0, 4'hf);
    apb(1'b1, 12'h000, 32'h0, 4'hf);
    rd(12'h000, 32'h0);
    check({31'h0, cmp_power_en}, 32'h0);
    check({30'h0, raw_compare_out, latched_compare_out}, 32'h0);
    stop_test();
  end
endmodule
